// *** bench/tb_rfpt_regs.sv ***
/*
 * tb_rfpt_regs: self-checking bench for the radio power and test register bank.
 * assumes: classic Wishbone slave acking one cycle after a request, registered pins.
 */
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin err_total++; \
   $display("Error %s expected %h seen %h", nm, e, a); end end
module tb_rfpt_regs;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [9:0] wb_adr_i = 10'h000;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   rfpt_pkg::rfpt_test_sig_t test_sig_i = '0;
   logic [2:0] port_zero_out_i = 3'h0;
   logic [2:0] port_zero_direction_i = 3'h0;
   logic [2:0] port_zero_pin_o;
   logic [2:0] port_zero_pin_oe_o;
   rfpt_pkg::rfpt_rf_ctrl_t rf_ctrl_o;
   logic [4:0] freq_shaping_n_o [7];
   int err_total = 0;
   int n_tests = 0;
   int cyc_cnt = 0;
   logic [31:0] rd;
   logic [$bits(rfpt_pkg::rfpt_test_sig_t)-1:0] pat;

   rfpt_regs rfpt_regs_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .test_sig_i(test_sig_i),
      .port_zero_out_i(port_zero_out_i), .port_zero_direction_i(port_zero_direction_i),
      .port_zero_pin_o(port_zero_pin_o), .port_zero_pin_oe_o(port_zero_pin_oe_o),
      .rf_ctrl_o(rf_ctrl_o), .freq_shaping_n_o(freq_shaping_n_o)
   );

   always #2.5 clk_i = ~clk_i;

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // hang guard, the whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 5000) begin
         err_total++;
         summarize();
      end
   end

   // one classic cycle, held until ack is sampled high
   task automatic wb_acc(input logic we, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'h1;
      wb_dat_i <= {24'h00_0000, wd};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      if (n >= 50) begin
         err_total++;
         $display("Error bus ack expected 1 seen none");
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e, input string nm);
      wb_acc(1'b0, idx, 8'h00);
      `CHK(nm, {24'h00_0000, e}, rd)
   endtask

   // let a committed write reach the registered outputs
   task automatic settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   function automatic logic [2:0] route_exp(input logic [3:0] c,
                                            input rfpt_pkg::rfpt_test_sig_t t,
                                            input logic [2:0] n);
      case (c)
         4'h0: return n;
         4'h1: return {t.clk_ref, t.phase_detector_out, t.modem_transmit_out};
         4'h2: return {t.lock_detect_filtered, t.lock_detect_raw, t.window_sync};
         4'h3: return {t.serial_parallel_int, t.second_timer_int, t.third_timer_int};
         4'h4: return {t.rtc_int, t.converter_int, t.cipher_int};
         4'h5: return {t.alarm_high, t.alarm_low, t.calibration_done};
         4'h6: return {t.modem_bit_clk, t.modem_rx_data, t.if_out};
         4'h7: return {t.modem_bit_clk, t.modem_tx_data, t.modem_transmit_out};
         4'h8: return {t.sar_clk_en, t.comparator, t.sar_end_of_conv};
         4'h9: return {t.rtc_clk, t.rtc_int, t.cpu_clk};
         4'hA, 4'hB, 4'hC, 4'hD: return {t.cipher_debug[c - 4'hA], n[1:0]};
         4'hE: return {t.flash_write_int, n[1:0]};
         default: return {t.calibration_done, n[1:0]};
      endcase
   endfunction

   initial begin
      for (int i = 0; i < $bits(pat); i++)
         pat[i] = (i % 3 == 1);
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values
      rd_chk(rfpt_pkg::IDX_TX_POWER, 8'h0F, "power reset");
      `CHK("high array", 4'h0, rf_ctrl_o.high_array_level)
      `CHK("low array", 4'hF, rf_ctrl_o.low_array_level)
      rd_chk(rfpt_pkg::IDX_SHAPE_DELAY, 8'h2F, "delay reset");
      rd_chk(rfpt_pkg::IDX_PRESCALER, 8'h00, "prescaler reset");
      rd_chk(rfpt_pkg::IDX_SYNTH_CTRL, 8'h01, "synth reset");
      rd_chk(rfpt_pkg::IDX_TEST_SEL, 8'h00, "select reset");
      rd_chk(8'h00, 8'h00, "unmapped read");
      $display("test reset done");
      // power nibbles and clearing for power-down
      wb_acc(1'b1, rfpt_pkg::IDX_TX_POWER, 8'hA5);
      settle();
      `CHK("high array", 4'hA, rf_ctrl_o.high_array_level)
      `CHK("low array", 4'h5, rf_ctrl_o.low_array_level)
      wb_acc(1'b1, rfpt_pkg::IDX_TX_POWER, 8'h00);
      rd_chk(rfpt_pkg::IDX_TX_POWER, 8'h00, "power cleared");
      // strength output, divider reset and loop filter
      wb_acc(1'b1, rfpt_pkg::IDX_FRONT_END, 8'h02);
      settle();
      `CHK("rssi on", 1'b1, rf_ctrl_o.rssi_connect)
      `CHK("front end out", 8'h02, rf_ctrl_o.front_end_control)
      wb_acc(1'b1, rfpt_pkg::IDX_FRONT_END, 8'h00);
      settle();
      `CHK("rssi off", 1'b0, rf_ctrl_o.rssi_connect)
      wb_acc(1'b1, rfpt_pkg::IDX_SYNTH_CTRL, 8'h00);
      wb_acc(1'b1, rfpt_pkg::IDX_PRESCALER, 8'h00);
      settle();
      `CHK("divider held", 1'b0, rf_ctrl_o.synth_divider_reset_n)
      `CHK("prescaler out", 8'h00, rf_ctrl_o.prescaler)
      wb_acc(1'b1, rfpt_pkg::IDX_SYNTH_CTRL, 8'hFF);
      rd_chk(rfpt_pkg::IDX_SYNTH_CTRL, 8'h1F, "synth top bits");
      `CHK("divider released", 1'b1, rf_ctrl_o.synth_divider_reset_n)
      `CHK("external_loop_filter_select", 1'b1, rf_ctrl_o.external_loop_filter_select)
      `CHK("synth out", 5'h1F, rf_ctrl_o.synth_control)
      wb_acc(1'b1, rfpt_pkg::IDX_SYNTH_CTRL, 8'h01);
      settle();
      `CHK("int filter", 1'b0, rf_ctrl_o.external_loop_filter_select)
      $display("test controls done");
      // shaping registers, five bits each
      for (int k = 0; k < rfpt_pkg::SHAPE_COUNT; k++)
         wb_acc(1'b1, rfpt_pkg::IDX_SHAPE_FIRST + 8'(k), 8'hE0 | 8'(k + 3));
      for (int k = 0; k < rfpt_pkg::SHAPE_COUNT; k++) begin
         rd_chk(rfpt_pkg::IDX_SHAPE_FIRST + 8'(k), 8'(k + 3), "shaping read");
         `CHK("shaping out", 5'(k + 3), freq_shaping_n_o[k])
      end
      wb_acc(1'b1, rfpt_pkg::IDX_SHAPE_DELAY, 8'hC3);
      rd_chk(rfpt_pkg::IDX_SHAPE_DELAY, 8'hC3, "delay rw");
      `CHK("delay out", 8'hC3, rf_ctrl_o.shaping_delay_ctrl)
      $display("test shaping done");
      // every test select code, two signal patterns, changing directions
      for (int c = 0; c < 16; c++) begin
         wb_acc(1'b1, rfpt_pkg::IDX_TEST_SEL, 8'(c));
         for (int p = 0; p < 2; p++) begin
            @(posedge clk_i);
            test_sig_i <= rfpt_pkg::rfpt_test_sig_t'(p ? ~pat : pat);
            port_zero_out_i <= p ? 3'h2 : 3'h5;
            port_zero_direction_i <= p ? 3'h6 : 3'h1;
            settle();
            `CHK("pin", route_exp(4'(c), test_sig_i, port_zero_out_i), port_zero_pin_o)
            `CHK("pin oe", port_zero_direction_i, port_zero_pin_oe_o)
         end
      end
      wb_acc(1'b1, rfpt_pkg::IDX_TEST_SEL, 8'hFF);
      rd_chk(rfpt_pkg::IDX_TEST_SEL, 8'h0F, "select top bits");
      wb_acc(1'b1, rfpt_pkg::IDX_TEST_SEL, 8'h00);
      rd_chk(rfpt_pkg::IDX_TEST_SEL, 8'h00, "select back to normal");
      $display("test routing done");
      // mid-run reset brings back the defaults
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(rfpt_pkg::IDX_TX_POWER, 8'h0F, "power reset again");
      rd_chk(rfpt_pkg::IDX_SHAPE_DELAY, 8'h2F, "delay reset again");
      $display("test mid-run reset done");
      summarize();
   end
endmodule

// *** common/rfpt_pkg.sv ***
/*
 * rfpt_pkg: constants and carrier types for the rf power and test register bank.
 * assumes: register indices times four give Wishbone byte addresses; data in bits 7:0.
 */
package rfpt_pkg;
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_MATCHLESS_BASE = 8'hDC;
   localparam logic [7:0] IDX_TX_POWER = 8'hE2;
   localparam logic [7:0] IDX_PRESCALER = 8'hE6;
   localparam logic [7:0] IDX_SHAPE_DELAY = 8'hE9;
   localparam logic [7:0] IDX_SYNTH_CTRL = 8'hEC;
   localparam logic [7:0] IDX_FRONT_END = 8'hEE;
   localparam logic [7:0] IDX_TEST_SEL = 8'hEF;
   localparam logic [7:0] IDX_SHAPE_FIRST = 8'hF1;
   localparam logic [7:0] IDX_SHAPE_LAST = 8'hF7;
   localparam int SHAPE_COUNT = 7;
   // values after reset
   localparam logic [7:0] RST_TX_POWER = 8'h0F;
   localparam logic [7:0] RST_PRESCALER = 8'h00;
   localparam logic [7:0] RST_SHAPE_DELAY = 8'h2F;
   localparam logic [4:0] RST_SYNTH_CTRL = 5'h01;
   localparam logic [7:0] RST_FRONT_END = 8'h00;
   localparam logic [3:0] RST_TEST_SEL = 4'h0;
   localparam logic [4:0] RST_SHAPE = 5'h00;
   // field positions
   localparam int POS_RSSI_EN = 1;
   localparam int POS_DIV_RESET_N = 0;
   localparam int POS_EXTERNAL_LOOP_FILTER_SELECT = 4;
   // test select codes
   localparam logic [3:0] TS_NORMAL = 4'h0;
   localparam logic [3:0] TS_CLOCKS = 4'h1;
   localparam logic [3:0] TS_LOCK = 4'h2;
   localparam logic [3:0] TS_INT_A = 4'h3;
   localparam logic [3:0] TS_INT_B = 4'h4;
   localparam logic [3:0] TS_ALARM = 4'h5;
   localparam logic [3:0] TS_MODEM_RX = 4'h6;
   localparam logic [3:0] TS_MODEM_TX = 4'h7;
   localparam logic [3:0] TS_CONVERTER = 4'h8;
   localparam logic [3:0] TS_SLOW_CLK = 4'h9;
   localparam logic [3:0] TS_DEBUG_0 = 4'hA;
   localparam logic [3:0] TS_DEBUG_3 = 4'hD;
   localparam logic [3:0] TS_FLASH = 4'hE;
   localparam logic [3:0] TS_CAL = 4'hF;

   typedef struct packed {
      logic clk_ref;
      logic phase_detector_out;
      logic modem_transmit_out;
      logic lock_detect_filtered;
      logic lock_detect_raw;
      logic window_sync;
      logic serial_parallel_int;
      logic second_timer_int;
      logic third_timer_int;
      logic rtc_int;
      logic converter_int;
      logic cipher_int;
      logic alarm_high;
      logic alarm_low;
      logic calibration_done;
      logic modem_bit_clk;
      logic modem_rx_data;
      logic if_out;
      logic modem_tx_data;
      logic sar_clk_en;
      logic comparator;
      logic sar_end_of_conv;
      logic rtc_clk;
      logic cpu_clk;
      logic [3:0] cipher_debug;
      logic flash_write_int;
   } rfpt_test_sig_t;

   typedef struct packed {
      logic [3:0] high_array_level;
      logic [3:0] low_array_level;
      logic rssi_connect;
      logic synth_divider_reset_n;
      logic external_loop_filter_select;
      logic [7:0] prescaler;
      logic [7:0] front_end_control;
      logic [4:0] synth_control;
      logic [7:0] shaping_delay_ctrl;
   } rfpt_rf_ctrl_t;
endpackage

// *** verilog/rfpt_regs.sv ***
/*
 * rfpt_regs: radio power, synthesiser and test routing register bank on a
 * classic Wishbone slave, with the port-0 test multiplexer.
 * assumes: one clock, synchronous reset; test signals come from logic on clk_i;
 * port-0 direction bit high means output.
 */
// Local design decision: the Wishbone interface to the registers.
// Function
// - power byte upper nibble: high array, reset 0
// - power byte lower nibble: low array, reset ones
// - strength output connected only while enable set
// - divider reset active low, bit 0, reset value one releases it
// - filter bit selects external loop filter
// - code zero: port-0 pins keep normal function
// - codes one, two: clocks and lock signals
// - codes three, four: interrupt lines routed out
// - codes ten up: debug, flash, calibration bit 2
// - seven five-bit shaping registers, top bits zero
// - shaping delay byte resets to 2F
// - port-0 direction from direction register in every test code, cleared to zero by reset
`timescale 1ns/100ps
module rfpt_regs (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // internal signals for test routing
   input wire rfpt_pkg::rfpt_test_sig_t test_sig_i,
   // port-0 normal function and direction
   input wire logic [2:0] port_zero_out_i,
   input wire logic [2:0] port_zero_direction_i,
   // port-0 pin drive
   output logic [2:0] port_zero_pin_o,
   output logic [2:0] port_zero_pin_oe_o,
   // radio controls
   output rfpt_pkg::rfpt_rf_ctrl_t rf_ctrl_o,
   output logic [4:0] freq_shaping_n_o [7]
);

   typedef struct packed {
      logic ack;
      logic [7:0] rdata;
      logic [7:0] tx_power;
      logic [7:0] prescaler;
      logic [7:0] shape_delay;
      logic [4:0] synth_ctrl;
      logic [7:0] front_end;
      logic [3:0] test_sel;
      logic [6:0][4:0] shape;
      logic [2:0] pin;
      logic [2:0] pin_oe;
   } rfpt_state_t;

   localparam rfpt_state_t ST_RESET = '{
      ack: 1'b0,
      rdata: 8'h00,
      tx_power: rfpt_pkg::RST_TX_POWER,
      prescaler: rfpt_pkg::RST_PRESCALER,
      shape_delay: rfpt_pkg::RST_SHAPE_DELAY,
      synth_ctrl: rfpt_pkg::RST_SYNTH_CTRL,
      front_end: rfpt_pkg::RST_FRONT_END,
      test_sel: rfpt_pkg::RST_TEST_SEL,
      shape: {7{rfpt_pkg::RST_SHAPE}},
      pin: 3'h0,
      pin_oe: 3'h0
   };

   rfpt_state_t st_r;
   rfpt_state_t st_nxt;

   // true when the word index falls in the shaping range
   function automatic logic is_shape(input logic [7:0] idx);
      is_shape = (idx >= rfpt_pkg::IDX_SHAPE_FIRST) && (idx <= rfpt_pkg::IDX_SHAPE_LAST);
   endfunction

   // read value of one register word, zero when unmapped
   function automatic logic [7:0] read_word(input rfpt_state_t s, input logic [7:0] idx);
      logic [2:0] n;
      n = 3'(idx - rfpt_pkg::IDX_SHAPE_FIRST);
      read_word = 8'h00;
      if (is_shape(idx)) begin
         read_word = {3'h0, s.shape[n]};
      end else begin
         unique case (idx)
            rfpt_pkg::IDX_TX_POWER: read_word = s.tx_power;
            rfpt_pkg::IDX_PRESCALER: read_word = s.prescaler;
            rfpt_pkg::IDX_SHAPE_DELAY: read_word = s.shape_delay;
            rfpt_pkg::IDX_SYNTH_CTRL: read_word = {3'h0, s.synth_ctrl};
            rfpt_pkg::IDX_FRONT_END: read_word = s.front_end;
            rfpt_pkg::IDX_TEST_SEL: read_word = {4'h0, s.test_sel};
            default: read_word = 8'h00;
         endcase
      end
   endfunction

   // port-0 value for one test code
   function automatic logic [2:0] route(input logic [3:0] code,
                                        input rfpt_pkg::rfpt_test_sig_t t,
                                        input logic [2:0] normal);
      route = normal;
      unique case (code)
         rfpt_pkg::TS_NORMAL: route = normal;
         rfpt_pkg::TS_CLOCKS:
            route = {t.clk_ref, t.phase_detector_out, t.modem_transmit_out};
         rfpt_pkg::TS_LOCK:
            route = {t.lock_detect_filtered, t.lock_detect_raw, t.window_sync};
         rfpt_pkg::TS_INT_A:
            route = {t.serial_parallel_int, t.second_timer_int, t.third_timer_int};
         rfpt_pkg::TS_INT_B:
            route = {t.rtc_int, t.converter_int, t.cipher_int};
         rfpt_pkg::TS_ALARM:
            route = {t.alarm_high, t.alarm_low, t.calibration_done};
         rfpt_pkg::TS_MODEM_RX:
            route = {t.modem_bit_clk, t.modem_rx_data, t.if_out};
         rfpt_pkg::TS_MODEM_TX:
            route = {t.modem_bit_clk, t.modem_tx_data, t.modem_transmit_out};
         rfpt_pkg::TS_CONVERTER:
            route = {t.sar_clk_en, t.comparator, t.sar_end_of_conv};
         rfpt_pkg::TS_SLOW_CLK:
            route = {t.rtc_clk, t.rtc_int, t.cpu_clk};
         rfpt_pkg::TS_FLASH:
            route = {t.flash_write_int, normal[1:0]};
         rfpt_pkg::TS_CAL:
            route = {t.calibration_done, normal[1:0]};
         default:
            // codes ten to thirteen: one debug line on bit 2
            route = {t.cipher_debug[2'(code - rfpt_pkg::TS_DEBUG_0)], normal[1:0]};
      endcase
   endfunction

   logic [7:0] idx;
   logic req;
   logic wr;
   logic [7:0] wd;
   logic [2:0] wn;

   assign idx = wb_adr_i[9:2];
   assign req = wb_cyc_i && wb_stb_i;
   // write commits at the edge where the master samples ack
   assign wr = req && wb_we_i && wb_sel_i[0] && st_r.ack;
   assign wd = wb_dat_i[7:0];
   assign wn = 3'(idx - rfpt_pkg::IDX_SHAPE_FIRST);

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = req && !st_r.ack;
      if (req && !st_r.ack) begin
         st_nxt.rdata = read_word(st_r, idx);
      end
      if (wr) begin
         if (is_shape(idx)) begin
            st_nxt.shape[wn] = wd[4:0];
         end
         unique case (idx)
            rfpt_pkg::IDX_TX_POWER: st_nxt.tx_power = wd;
            rfpt_pkg::IDX_PRESCALER: st_nxt.prescaler = wd;
            rfpt_pkg::IDX_SHAPE_DELAY: st_nxt.shape_delay = wd;
            rfpt_pkg::IDX_SYNTH_CTRL: st_nxt.synth_ctrl = wd[4:0];
            rfpt_pkg::IDX_FRONT_END: st_nxt.front_end = wd;
            rfpt_pkg::IDX_TEST_SEL: st_nxt.test_sel = wd[3:0];
            default: st_nxt.ack = st_nxt.ack;
         endcase
      end
      st_nxt.pin = route(st_r.test_sel, test_sig_i, port_zero_out_i);
      st_nxt.pin_oe = port_zero_direction_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= ST_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wb_ack_o = st_r.ack;
   assign wb_dat_o = {24'h000000, st_r.rdata};
   assign port_zero_pin_o = st_r.pin;
   assign port_zero_pin_oe_o = st_r.pin_oe;

   always_comb begin
      rf_ctrl_o.high_array_level = st_r.tx_power[7:4];
      rf_ctrl_o.low_array_level = st_r.tx_power[3:0];
      rf_ctrl_o.rssi_connect = st_r.front_end[rfpt_pkg::POS_RSSI_EN];
      rf_ctrl_o.synth_divider_reset_n = st_r.synth_ctrl[rfpt_pkg::POS_DIV_RESET_N];
      rf_ctrl_o.external_loop_filter_select =
         st_r.synth_ctrl[rfpt_pkg::POS_EXTERNAL_LOOP_FILTER_SELECT];
      rf_ctrl_o.prescaler = st_r.prescaler;
      rf_ctrl_o.front_end_control = st_r.front_end;
      rf_ctrl_o.synth_control = st_r.synth_ctrl;
      rf_ctrl_o.shaping_delay_ctrl = st_r.shape_delay;
   end

   for (genvar g = 0; g < rfpt_pkg::SHAPE_COUNT; g++) begin : g_shape
      assign freq_shaping_n_o[g] = st_r.shape[g];
   end

   // checks; pin checks skip the release edge, where the pins still load reset
   a_power_reset: assert property (@(posedge clk_i)
      $past(rst_i) && !rst_i |->
      rf_ctrl_o.high_array_level == 4'h0 && rf_ctrl_o.low_array_level == 4'hF)
      else $error("power level wrong after reset");

   a_power_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == rfpt_pkg::IDX_TX_POWER |=>
      rf_ctrl_o.low_array_level == $past(wb_dat_i[3:0]) &&
      rf_ctrl_o.high_array_level == $past(wb_dat_i[7:4]))
      else $error("power nibbles not stored");

   a_rssi_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == rfpt_pkg::IDX_FRONT_END |=>
      rf_ctrl_o.rssi_connect == $past(wb_dat_i[rfpt_pkg::POS_RSSI_EN]))
      else $error("strength output not tied to enable");

   a_rssi_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !(wr && idx == rfpt_pkg::IDX_FRONT_END) |=> $stable(rf_ctrl_o.rssi_connect))
      else $error("strength output changed without a write");

   a_div_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !rf_ctrl_o.synth_divider_reset_n && !(wr && idx == rfpt_pkg::IDX_SYNTH_CTRL) |=>
      !rf_ctrl_o.synth_divider_reset_n)
      else $error("divider left reset without a write");

   a_div_release: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == rfpt_pkg::IDX_SYNTH_CTRL |=>
      rf_ctrl_o.synth_divider_reset_n == $past(wb_dat_i[rfpt_pkg::POS_DIV_RESET_N]))
      else $error("divider reset bit not stored");

   a_filter_sel: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == rfpt_pkg::IDX_SYNTH_CTRL |=>
      rf_ctrl_o.external_loop_filter_select == $past(wb_dat_i[rfpt_pkg::POS_EXTERNAL_LOOP_FILTER_SELECT]))
      else $error("loop filter select not stored");

   a_mux_normal: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i && st_r.test_sel == 4'h0 && $stable(st_r.test_sel) |=>
      port_zero_pin_o == $past(port_zero_out_i))
      else $error("normal pins overridden");

   a_mux_clocks: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i && st_r.test_sel == 4'h1 |=> port_zero_pin_o ==
      {$past(test_sig_i.clk_ref), $past(test_sig_i.phase_detector_out),
       $past(test_sig_i.modem_transmit_out)})
      else $error("clock routing wrong");

   a_mux_lock: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i && st_r.test_sel == 4'h2 |=> port_zero_pin_o ==
      {$past(test_sig_i.lock_detect_filtered), $past(test_sig_i.lock_detect_raw),
       $past(test_sig_i.window_sync)})
      else $error("lock routing wrong");

   a_mux_int_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i && st_r.test_sel == 4'h3 |=> port_zero_pin_o ==
      {$past(test_sig_i.serial_parallel_int), $past(test_sig_i.second_timer_int),
       $past(test_sig_i.third_timer_int)})
      else $error("first interrupt routing wrong");

   a_mux_ints: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i && st_r.test_sel == 4'h4 |=> port_zero_pin_o ==
      {$past(test_sig_i.rtc_int), $past(test_sig_i.converter_int),
       $past(test_sig_i.cipher_int)})
      else $error("interrupt routing wrong");

   a_mux_debug: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i && st_r.test_sel >= 4'hA |=>
      port_zero_pin_o[1:0] == $past(port_zero_out_i[1:0]))
      else $error("low pins taken by single-bit code");

   a_debug_line: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i && st_r.test_sel == 4'hA |=>
      port_zero_pin_o[2] == $past(test_sig_i.cipher_debug[0]))
      else $error("debug line routing wrong");

   a_mux_flash: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i && st_r.test_sel == 4'hE |=>
      port_zero_pin_o[2] == $past(test_sig_i.flash_write_int))
      else $error("flash interrupt routing wrong");

   a_mux_cal: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i && st_r.test_sel == 4'hF |=>
      port_zero_pin_o[2] == $past(test_sig_i.calibration_done))
      else $error("calibration flag routing wrong");

   a_shape_top: assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.ack && !wb_we_i && is_shape(idx) |-> wb_dat_o[7:5] == 3'h0)
      else $error("shaping upper bits not zero");

   a_shape_first: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == rfpt_pkg::IDX_SHAPE_FIRST |=>
      freq_shaping_n_o[0] == $past(wb_dat_i[4:0]))
      else $error("first shaping field not stored");

   a_delay_reset: assert property (@(posedge clk_i)
      $past(rst_i) && !rst_i |-> rf_ctrl_o.shaping_delay_ctrl == 8'h2F)
      else $error("delay register reset wrong");

   a_delay_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == rfpt_pkg::IDX_SHAPE_DELAY |=>
      rf_ctrl_o.shaping_delay_ctrl == $past(wb_dat_i[7:0]))
      else $error("delay register not stored");

   a_dir_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i |=> port_zero_pin_oe_o == $past(port_zero_direction_i))
      else $error("pin direction not from direction register");

   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

endmodule
